/* File: hdl/hbgd_gate_ctl.sv */
// gate drive control for three half-bridges: registers, protection,
// cycle-by-cycle limit, swap, dead time, delays and driver output stage
// assumes pwm, fault and comparator inputs are synchronous to clk
`timescale 1ns/100ps
module hbgd_gate_ctl (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic [2:0] pwmHi,
    input wire logic [2:0] pwmLo,
    input wire logic faultNotify,
    input wire logic [2:0] highFaultCmp,
    input wire logic [2:0] lowFaultCmp,
    output logic [2:0] hsGateUp,
    output logic [2:0] hsGateDn,
    output logic [2:0] lsGateUp,
    output logic [2:0] lsGateDn,
    output logic wdtRestart
);
    localparam logic [2:0] DEAD_CNT = 3'(hbgd_pkg::DEAD_CYC);

    logic [7:0] delayCfgA;
    logic [7:0] delayProtCfg;
    logic [7:0] swapLimitCfg;
    logic [7:0] cmpMaskCfg;
    logic [7:0] wdtField;
    logic mgrEnable;
    logic hsTrip;
    logic lsTrip;
    logic cycleLimitEvent;
    logic [2:0] latchedDisable;
    logic [2:0] liveDisable;
    logic [2:0] pairEvent;
    logic [2:0] swapSel;
    logic [2:0] limitSel;
    logic [2:0] cmpUnmaskHi;
    logic [2:0] cmpUnmaskLo;
    logic hsLimitSel;
    logic lsLimitSel;
    logic deadEn;
    logic extOn;
    logic [2:0] swHi;
    logic [2:0] swLo;
    logic [2:0] dtHi;
    logic [2:0] dtLo;
    logic [2:0] dlHi;
    logic [2:0] dlLo;
    logic [2:0] wantHs;
    logic [2:0] wantLs;

    // address match used by the watchdog strobe, the status clear and the assertions
    function automatic logic hit(input logic en, input logic [6:0] addr,
                                 input logic [6:0] target);
        hit = en && addr == target;
    endfunction : hit

    // configuration fields
    assign swapSel = swapLimitCfg[hbgd_pkg::POS_SWAP +: 3];
    assign limitSel = swapLimitCfg[hbgd_pkg::POS_LIMIT_SEL +: 3];
    assign hsLimitSel = swapLimitCfg[hbgd_pkg::POS_HS_LIMIT];
    assign lsLimitSel = swapLimitCfg[hbgd_pkg::POS_LS_LIMIT];
    assign deadEn = delayProtCfg[hbgd_pkg::POS_DEAD_EN];
    assign extOn = !delayProtCfg[hbgd_pkg::POS_EXT_OFF];
    assign cmpUnmaskHi = {cmpMaskCfg[7], cmpMaskCfg[5], cmpMaskCfg[3]};
    assign cmpUnmaskLo = {cmpMaskCfg[6], cmpMaskCfg[4], cmpMaskCfg[2]};

    // config writes; reserved bits are forced to zero so they read back 0
    always_ff @(posedge clk) begin
        if (srst) begin
            delayCfgA <= hbgd_pkg::RST_CFG;
            delayProtCfg <= hbgd_pkg::RST_CFG;
            swapLimitCfg <= hbgd_pkg::RST_CFG;
            cmpMaskCfg <= hbgd_pkg::RST_CFG;
            wdtField <= hbgd_pkg::RST_WDT;
            mgrEnable <= 1'b0;
        end else if (ce && regWrEn) begin
            case (regAddr)
                hbgd_pkg::ADDR_DELAY_A: delayCfgA <= regWrData;
                hbgd_pkg::ADDR_DELAY_PROT: delayProtCfg <= regWrData;
                hbgd_pkg::ADDR_SWAP_LIMIT: swapLimitCfg <= regWrData;
                hbgd_pkg::ADDR_CMP_MASK: begin
                    cmpMaskCfg <= regWrData & hbgd_pkg::CMP_MASK_WR;
                end
                hbgd_pkg::ADDR_ENABLE: begin
                    mgrEnable <= regWrData[hbgd_pkg::POS_ENABLE];
                end
                hbgd_pkg::ADDR_WDT_PASS: wdtField <= regWrData;
                default: ;
            endcase
        end
    end

    // watchdog restart strobe, one cycle after the password write
    always_ff @(posedge clk) begin
        if (srst) begin
            wdtRestart <= 1'b0;
        end else if (ce) begin
            wdtRestart <= hit(regWrEn, regAddr, hbgd_pkg::ADDR_WDT_PASS)
                && regWrData == hbgd_pkg::WDT_KEY;
        end
    end

    // protection latches; only an enable toggle re-arms the outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            hsTrip <= 1'b0;
            lsTrip <= 1'b0;
        end else if (ce) begin
            if (!mgrEnable) begin
                hsTrip <= 1'b0;
                lsTrip <= 1'b0;
            end else begin
                if (faultNotify && delayProtCfg[hbgd_pkg::POS_HS_UNMASK]) begin
                    hsTrip <= 1'b1;
                end
                if (faultNotify && delayProtCfg[hbgd_pkg::POS_LS_UNMASK]) begin
                    lsTrip <= 1'b1;
                end
            end
        end
    end

    // registered limit event; one cycle of latency traded for clean timing
    always_ff @(posedge clk) begin
        if (srst) begin
            cycleLimitEvent <= 1'b0;
        end else if (ce) begin
            cycleLimitEvent <= |(highFaultCmp & cmpUnmaskHi)
                | |(lowFaultCmp & cmpUnmaskLo);
        end
    end

    // live disable per pair, and what counts as a disable event
    assign liveDisable = {3{cycleLimitEvent && (hsLimitSel || lsLimitSel)}}
        & limitSel;
    assign pairEvent = liveDisable | {3{hsTrip || lsTrip}};

    // latched status: a new event wins over a write-one clear
    always_ff @(posedge clk) begin
        if (srst) begin
            latchedDisable <= hbgd_pkg::RST_STATUS;
        end else if (ce) begin
            if (hit(regWrEn, regAddr, hbgd_pkg::ADDR_STATUS)) begin
                latchedDisable <= pairEvent
                    | (latchedDisable & ~regWrData[2:0]);
            end else begin
                latchedDisable <= pairEvent | latchedDisable;
            end
        end
    end

    // read-back, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (ce && regRdEn) begin
            case (regAddr)
                hbgd_pkg::ADDR_DELAY_A: regRdData <= delayCfgA;
                hbgd_pkg::ADDR_DELAY_PROT: regRdData <= delayProtCfg;
                hbgd_pkg::ADDR_SWAP_LIMIT: regRdData <= swapLimitCfg;
                hbgd_pkg::ADDR_CMP_MASK: regRdData <= cmpMaskCfg;
                hbgd_pkg::ADDR_STATUS: begin
                    regRdData <= {2'h0, liveDisable, latchedDisable};
                end
                hbgd_pkg::ADDR_ENABLE: regRdData <= {7'h00, mgrEnable};
                hbgd_pkg::ADDR_WDT_PASS: regRdData <= wdtField;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // one slice per half-bridge: high index p is driver p+3, low is p
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : gPair
            logic [2:0] hiOff;
            logic [2:0] loOff;
            logic [1:0] hiDelaySel;

            if (p == 0) begin : gSelH
                assign hiDelaySel = delayCfgA[7:6];
            end else begin : gSelH
                assign hiDelaySel = delayProtCfg[2*p+2 +: 2];
            end

            // swap stage
            always_ff @(posedge clk) begin
                if (srst) begin
                    swHi[p] <= 1'b0;
                    swLo[p] <= 1'b0;
                end else if (ce) begin
                    swHi[p] <= swapSel[p] ? pwmLo[p] : pwmHi[p];
                    swLo[p] <= swapSel[p] ? pwmHi[p] : pwmLo[p];
                end
            end

            // cycles since each side went low, saturating at the dead time
            always_ff @(posedge clk) begin
                if (srst) begin
                    hiOff <= DEAD_CNT;
                    loOff <= DEAD_CNT;
                end else if (ce) begin
                    if (swHi[p]) begin
                        hiOff <= 3'h0;
                    end else if (hiOff != DEAD_CNT) begin
                        hiOff <= hiOff + 3'h1;
                    end
                    if (swLo[p]) begin
                        loOff <= 3'h0;
                    end else if (loOff != DEAD_CNT) begin
                        loOff <= loOff + 3'h1;
                    end
                end
            end

            // a side turns on only after its partner has been off long enough
            always_ff @(posedge clk) begin
                if (srst) begin
                    dtHi[p] <= 1'b0;
                    dtLo[p] <= 1'b0;
                end else if (ce) begin
                    if (deadEn) begin
                        dtHi[p] <= swHi[p] && !swLo[p]
                            && loOff == DEAD_CNT;
                        dtLo[p] <= swLo[p] && !swHi[p]
                            && hiOff == DEAD_CNT;
                    end else begin
                        dtHi[p] <= swHi[p];
                        dtLo[p] <= swLo[p];
                    end
                end
            end

            hbgd_out_path uHiPath (
                .clk(clk),
                .srst(srst),
                .ce(ce),
                .extOn(extOn),
                .delaySel(hiDelaySel),
                .din(dtHi[p]),
                .dout(dlHi[p])
            );

            hbgd_out_path uLoPath (
                .clk(clk),
                .srst(srst),
                .ce(ce),
                .extOn(extOn),
                .delaySel(delayCfgA[2*p +: 2]),
                .din(dtLo[p]),
                .dout(dlLo[p])
            );

            // gating by enable, protection latch and live limit
            always_ff @(posedge clk) begin
                if (srst) begin
                    wantHs[p] <= 1'b0;
                    wantLs[p] <= 1'b0;
                end else if (ce) begin
                    wantHs[p] <= dlHi[p] && mgrEnable && !hsTrip
                        && !(liveDisable[p] && hsLimitSel);
                    wantLs[p] <= dlLo[p] && mgrEnable && !lsTrip
                        && !(liveDisable[p] && lsLimitSel);
                end
            end

            // driver stage: the old transistor releases before the new one
            always_ff @(posedge clk) begin
                if (srst) begin
                    hsGateUp[p] <= 1'b0;
                    hsGateDn[p] <= 1'b1;
                    lsGateUp[p] <= 1'b0;
                    lsGateDn[p] <= 1'b1;
                end else if (ce) begin
                    hsGateUp[p] <= wantHs[p] && !hsGateDn[p];
                    hsGateDn[p] <= !wantHs[p] && !hsGateUp[p];
                    lsGateUp[p] <= wantLs[p] && !lsGateDn[p];
                    lsGateDn[p] <= !wantLs[p] && !lsGateUp[p];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_no_shoot_through: assert property (
        (hsGateUp & hsGateDn) == 3'h0 && (lsGateUp & lsGateDn) == 3'h0)
        else $error("pull-up and pull-down on together");
    a_want_off_disabled: assert property (
        ce && !mgrEnable |=> wantHs == 3'h0 && wantLs == 3'h0)
        else $error("gate request on while enable is low");
    a_off_when_disabled: assert property (
        ce && !mgrEnable ##1 ce |=> hsGateUp == 3'h0 && lsGateUp == 3'h0)
        else $error("outputs on while enable is low");
    a_hs_trip_sets: assert property (
        ce && mgrEnable && faultNotify
            && delayProtCfg[hbgd_pkg::POS_HS_UNMASK] |=> hsTrip)
        else $error("high-side protection did not latch");
    a_ls_trip_blocks: assert property (
        ce && lsTrip |=> wantLs == 3'h0)
        else $error("low side driven after protection trip");
    a_trip_holds: assert property (
        ce && hsTrip && mgrEnable |=> hsTrip)
        else $error("protection latch released without enable toggle");
    a_limit_kills_hs: assert property (
        ce && cycleLimitEvent && hsLimitSel
            |=> (wantHs & $past(limitSel)) == 3'h0)
        else $error("limit event did not disable selected high side");
    a_masked_cmp_ignored: assert property (
        ce && (highFaultCmp & cmpUnmaskHi) == 3'h0
            && (lowFaultCmp & cmpUnmaskLo) == 3'h0 |=> !cycleLimitEvent)
        else $error("masked comparator raised the limit event");
    a_live_status_read: assert property (
        ce && hit(regRdEn, regAddr, hbgd_pkg::ADDR_STATUS)
            |=> regRdData[5:3] == $past(liveDisable))
        else $error("live disable status wrong");
    a_latched_sticky: assert property (
        ce && pairEvent[0] |=> latchedDisable[0])
        else $error("disable event lost from latched status");
    a_wdt_restart: assert property (
        wdtRestart |-> $past(regWrEn) && $past(regWrData) == hbgd_pkg::WDT_KEY
            && $past(regAddr) == hbgd_pkg::ADDR_WDT_PASS)
        else $error("watchdog restart without password write");
    a_dead_time_gap: assert property (
        ce && deadEn && $rose(dtHi[0])
            |-> !dtLo[0] && $past(dtLo[0], 4) == 1'b0)
        else $error("dead time too short");
    a_reserved_zero: assert property (
        ce && hit(regRdEn, regAddr, hbgd_pkg::ADDR_ENABLE)
            |=> regRdData[7:1] == 7'h00)
        else $error("reserved enable bits not zero");

    c_limit_event: cover property (ce && cycleLimitEvent && liveDisable != 3'h0);
    c_hs_trip: cover property (ce && $rose(hsTrip));
    c_swap_used: cover property (ce && swapSel[1] && swHi[1]);
    c_rearm: cover property (hsTrip ##1 !mgrEnable ##[1:20] mgrEnable);
endmodule : hbgd_gate_ctl

/* File: hdl/hbgd_pkg.sv */
// constants shared by the half-bridge gate drive control and its output path
// assumes a single 40 MHz clock; all times are turned into cycle counts here
//
// Functional notes
// - gate outputs are driven only while driver_manager_enable is set.
// - unmasked protection event disables all three high-side gate outputs.
// - unmasked protection event disables all three low-side gate outputs.
// - protection disable holds until enable is cleared and set again.
// - per-pair swap bit exchanges the PWM inputs of high and low side.
// - limit event kills selected sides of pairs whose limit-select bit is set.
// - limit disable ends by itself as soon as the limit event falls.
// - status bits 2..0 latch disable events until software writes one.
// - a single driver never turns on pull-up and pull-down together.
// - dead time enable inserts 100ns gap between pair transitions.
// - two-bit selector per output adds 0, 50, 100 or 200ns delay.
// - pulse extension applies when pulse_ext_off is zero, not when one.
// - each comparator joins limiting only while its unmask bit is set.
// - writing ACh to the watchdog password restarts the watchdog.
// - reserved bits read as zero; software writes zeros there.
package hbgd_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEAD_TIME_NS = 100;
    localparam int DEAD_CYC =
        (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_SEL_LO1_NS = 50;
    localparam int DELAY_SEL_LO2_NS = 100;
    localparam int DELAY_SEL_HI3_NS = 200;
    localparam int DELAY_SEL_LO1_CYC = (DELAY_SEL_LO1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_SEL_LO2_CYC = (DELAY_SEL_LO2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_SEL_HI3_CYC = (DELAY_SEL_HI3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_EXT_NS = 50;
    localparam int PULSE_EXT_CYC =
        (PULSE_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_DEPTH = DELAY_SEL_HI3_CYC;
    // register offsets
    localparam logic [6:0] ADDR_DELAY_A = 7'h26;
    localparam logic [6:0] ADDR_DELAY_PROT = 7'h27;
    localparam logic [6:0] ADDR_SWAP_LIMIT = 7'h28;
    localparam logic [6:0] ADDR_CMP_MASK = 7'h29;
    localparam logic [6:0] ADDR_STATUS = 7'h2A;
    localparam logic [6:0] ADDR_ENABLE = 7'h7D;
    localparam logic [6:0] ADDR_WDT_PASS = 7'h7E;
    // values after reset
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_WDT = 8'h00;
    localparam logic [2:0] RST_STATUS = 3'h0;
    // field positions
    localparam int POS_ENABLE = 0;
    localparam int POS_HS_UNMASK = 3;
    localparam int POS_LS_UNMASK = 2;
    localparam int POS_EXT_OFF = 1;
    localparam int POS_DEAD_EN = 0;
    localparam int POS_HS_LIMIT = 0;
    localparam int POS_LS_LIMIT = 1;
    localparam int POS_LIMIT_SEL = 2;
    localparam int POS_SWAP = 5;
    localparam logic [7:0] CMP_MASK_WR = 8'hFC;
    localparam logic [7:0] WDT_KEY = 8'hAC;
endpackage : hbgd_pkg

/* File: hdl/hbgd_out_path.sv */
// one gate output path: pulse extension followed by a selectable delay line
// assumes din is already synchronous to clk
`timescale 1ns/100ps
module hbgd_out_path #(
    parameter int DEPTH = hbgd_pkg::DELAY_DEPTH,
    parameter int EXT = hbgd_pkg::PULSE_EXT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic extOn,
    input wire logic [1:0] delaySel,
    input wire logic din,
    output logic dout
);
    localparam logic [2:0] EXT_LOAD = 3'(EXT - 1);

    logic lastIn;
    logic [2:0] extCnt;
    logic extended;
    logic [DEPTH-1:0] tapLine;

    // tap index for each delay code, counted in whole clock cycles
    function automatic int tapIdx(input logic [1:0] code);
        case (code)
            2'h1: tapIdx = hbgd_pkg::DELAY_SEL_LO1_CYC - 1;
            2'h2: tapIdx = hbgd_pkg::DELAY_SEL_LO2_CYC - 1;
            default: tapIdx = hbgd_pkg::DELAY_SEL_HI3_CYC - 1;
        endcase
    endfunction : tapIdx

    // short pulses are held on for EXT cycles so the driver settles
    assign extended = din | (extOn && extCnt != 3'h0);

    always_ff @(posedge clk) begin
        if (srst) begin
            lastIn <= 1'b0;
            extCnt <= 3'h0;
        end else if (ce) begin
            lastIn <= din;
            if (din && !lastIn) begin
                extCnt <= EXT_LOAD;
            end else if (extCnt != 3'h0) begin
                extCnt <= extCnt - 3'h1;
            end
        end
    end

    // delay line shifts every enabled cycle; code zero bypasses it
    always_ff @(posedge clk) begin
        if (srst) begin
            tapLine <= '0;
            dout <= 1'b0;
        end else if (ce) begin
            tapLine <= {tapLine[DEPTH-2:0], extended};
            if (delaySel == 2'h0) begin
                dout <= extended;
            end else begin
                dout <= tapLine[tapIdx(delaySel)];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_zero_delay_pass: assert property (
        ce && delaySel == 2'h0 |=> dout == $past(extended))
        else $error("zero delay code does not pass straight through");
    a_delay_100ns: assert property (
        (ce && delaySel == 2'h2)[*6] |=> dout == $past(extended, 5))
        else $error("delay code 10 is not four cycles");
    a_pulse_stretch: assert property (
        ce && extOn && din && !lastIn ##1 ce |-> extended)
        else $error("pulse extension missing");
endmodule : hbgd_out_path

/* File: tb/hbgd_switch_model.sv */
// three external half-bridge switch pairs driven by the gate outputs
// assumes gate outputs are synchronous to clk; counts unsafe drive states
`timescale 1ns/100ps
module hbgd_switch_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] hsGateUp,
    input wire logic [2:0] hsGateDn,
    input wire logic [2:0] lsGateUp,
    input wire logic [2:0] lsGateDn,
    output logic [2:0] phaseOut,
    output int faults
);
    // a switch node left floating shows the inverse of its last level, so
    // a bench that relies on a stale phase sees a wrong value
    always_ff @(posedge clk) begin
        if (srst) faults <= 0;
        for (int p = 0; p < 3; p++) begin
            if (hsGateUp[p] === 1'b1) begin
                phaseOut[p] <= 1'b1;
            end else if (lsGateUp[p] === 1'b1) begin
                phaseOut[p] <= 1'b0;
            end else begin
                phaseOut[p] <= ~phaseOut[p];
            end
            // both switches of a pair on shorts the rail
            if (!srst && hsGateUp[p] && lsGateUp[p]) begin
                faults <= faults + 1;
            end
            if (!srst && hsGateUp[p] && hsGateDn[p]) begin
                faults <= faults + 1;
            end
            if (!srst && lsGateUp[p] && lsGateDn[p]) begin
                faults <= faults + 1;
            end
        end
    end
endmodule : hbgd_switch_model

/* File: tb/test_hbgd_gate_ctl.sv */
// self-checking bench for the gate drive control, expectations in a queue
// assumes the 40 MHz clock and the register strobes described for the block
`timescale 1ns/100ps
module test_hbgd_gate_ctl;
    logic clk = 0, srst = 1, ce = 1, regWrEn = 0, regRdEn = 0;
    logic [6:0] regAddr = '0;
    logic [7:0] regWrData = '0, regRdData;
    logic [2:0] pwmHi = '0, pwmLo = '0, highFaultCmp = '0, lowFaultCmp = '0;
    logic faultNotify = 0, wdtRestart, pendRd = 0, pendOb = 0, obReq = 0;
    logic [2:0] hsGateUp, hsGateDn, lsGateUp, lsGateDn, phaseOut;
    logic [15:0] obsVal = '0, expV, gotV, expQ[$];
    logic [11:0] gv;
    logic [31:0] seed = 32'h57;
    int nErrors = 0, totalChecks = 0, cycles = 0, wdtCnt = 0, swFaults;
    int n, base, n0, n1;
    int dly[4] = '{0, 2, 4, 8};
    logic [6:0] regs[7] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h7D, 7'h7E};
    logic [7:0] v;
    assign gv = {hsGateUp, hsGateDn, lsGateUp, lsGateDn};
    hbgd_gate_ctl i_dut (.clk(clk), .srst(srst), .ce(ce), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .pwmHi(pwmHi), .pwmLo(pwmLo),
        .faultNotify(faultNotify), .highFaultCmp(highFaultCmp),
        .lowFaultCmp(lowFaultCmp), .hsGateUp(hsGateUp), .hsGateDn(hsGateDn),
        .lsGateUp(lsGateUp), .lsGateDn(lsGateDn), .wdtRestart(wdtRestart));
    hbgd_switch_model i_sw (.clk(clk), .srst(srst), .hsGateUp(hsGateUp),
        .hsGateDn(hsGateDn), .lsGateUp(lsGateUp), .lsGateDn(lsGateDn),
        .phaseOut(phaseOut), .faults(swFaults));
    // free-running 25 ns clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    function automatic logic [15:0] g(input logic [2:0] h,
                                      input logic [2:0] l);
        return {4'h0, h, ~h, l, ~l};
    endfunction : g
    task conclude();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // strobes stay up for exactly one taken edge, then drop
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 0;
    endtask : wr
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        regRdEn <= 1;
        regAddr <= a;
        expQ.push_back({8'h00, e});
        @(posedge clk);
        regRdEn <= 0;
    endtask : rd
    task chk(input logic [15:0] o, input logic [15:0] e);
        @(posedge clk);
        obReq <= 1;
        obsVal <= o;
        expQ.push_back(e);
        @(posedge clk);
        obReq <= 0;
    endtask : chk
    task waitc(input int c);
        repeat (c) @(posedge clk);
    endtask : waitc
    // cycles from a low-side request until its pull-up turns on
    task lat(output int c);
        pwmLo[0] <= 1;
        c = 0;
        while (lsGateUp[0] !== 1'b1 && c < 40) begin
            @(posedge clk);
            c++;
        end
        pwmLo[0] <= 0;
        waitc(30);
    endtask : lat
    // one-cycle request; counts cycles with the pull-down released
    task pls(output int c);
        pwmLo[0] <= 1;
        @(posedge clk);
        pwmLo[0] <= 0;
        c = 0;
        repeat (30) begin
            @(posedge clk);
            if (lsGateDn[0] === 1'b0) c++;
        end
    endtask : pls
    // a result is due at the falling edge after its taken request
    always @(posedge clk) begin
        pendRd <= regRdEn;
        pendOb <= obReq;
        if (wdtRestart === 1'b1) wdtCnt <= wdtCnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            conclude();
        end
    end
    always @(negedge clk) begin
        if (pendRd || pendOb) begin
            expV = expQ.pop_front();
            gotV = pendRd ? {8'h00, regRdData} : obsVal;
            totalChecks++;
            if (gotV !== expV) begin
                nErrors++;
                $display("unexpected at %0t: got %h want %h", $time, gotV,
                    expV);
            end
        end
    end
    initial begin
        waitc(5);
        srst <= 0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(7'h30, 8'h00);
        chk({4'h0, gv}, g(0, 0));
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            wr(7'h26 + i[6:0], v);
            rd(7'h26 + i[6:0], v);
        end
        wr(7'h29, 8'hFF);
        rd(7'h29, 8'hFC);
        wr(7'h7D, 8'hFF);
        rd(7'h7D, 8'h01);
        wr(7'h2A, 8'hFF);
        rd(7'h2A, 8'h00);
        wr(7'h7E, 8'hAC);
        wr(7'h7E, 8'h55);
        rd(7'h7E, 8'h55);
        chk(wdtCnt[15:0], 16'h1);
        wr(7'h7D, 0);
        wr(7'h29, 0);
        wr(7'h28, 0);
        wr(7'h26, 0);
        wr(7'h27, 8'h02);
        pwmHi <= 3'b101;
        pwmLo <= 3'b010;
        waitc(20);
        chk({4'h0, gv}, g(0, 0));
        wr(7'h7D, 1);
        waitc(20);
        chk({4'h0, gv}, g(5, 2));
        chk({13'h0, phaseOut}, 16'h5);
        wr(7'h28, 8'hE0);
        waitc(20);
        chk({4'h0, gv}, g(2, 5));
        wr(7'h28, 8'h1D);
        wr(7'h29, 8'h08);
        highFaultCmp <= 3'b001;
        lowFaultCmp <= 3'b111;
        waitc(20);
        chk({4'h0, gv}, g(0, 2));
        rd(7'h2A, 8'h3F);
        highFaultCmp <= 0;
        lowFaultCmp <= 0;
        waitc(20);
        chk({4'h0, gv}, g(5, 2));
        rd(7'h2A, 8'h07);
        wr(7'h2A, 8'h07);
        rd(7'h2A, 8'h00);
        wr(7'h28, 0);
        wr(7'h29, 0);
        for (int k = 0; k < 2; k++) begin
            wr(7'h27, k ? 8'h06 : 8'h0A);
            faultNotify <= 1;
            @(posedge clk);
            faultNotify <= 0;
            waitc(20);
            chk({4'h0, gv}, k ? g(5, 0) : g(0, 2));
            wr(7'h7D, 0);
            wr(7'h7D, 1);
            wr(7'h2A, 8'h07);
            waitc(20);
            chk({4'h0, gv}, g(5, 2));
        end
        wr(7'h27, 8'h03);
        pwmLo <= 3'b011;
        waitc(20);
        chk({4'h0, gv}, g(4, 2));
        // drop both inputs before dead time goes off, else pair 0 shorts
        pwmHi <= 0;
        pwmLo <= 0;
        waitc(20);
        wr(7'h27, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(7'h26, c[7:0]);
            lat(n);
            if (c == 0) base = n;
            chk(16'(n - base), 16'(dly[c]));
        end
        wr(7'h26, 0);
        wr(7'h27, 8'h00);
        pls(n1);
        wr(7'h27, 8'h02);
        pls(n0);
        chk({15'h0, n1 > n0}, 16'h1);
        chk(swFaults[15:0], 16'h0);
        waitc(4);
        conclude();
    end
endmodule : test_hbgd_gate_ctl
